//--- dopc_pkg.sv
// Package for the digital output port control block: map, fields, timing
package dopc_pkg;

  localparam int NUM_LINES = 4;

  // Register byte offsets
  localparam logic [7:0] ADDR_STATE   = 8'h00;
  localparam logic [7:0] ADDR_TOGGLE  = 8'h04;
  localparam logic [7:0] ADDR_SENSE   = 8'h08;
  localparam logic [7:0] ADDR_CTRL    = 8'h0C;
  localparam logic [7:0] ADDR_PATTERN = 8'h10;
  localparam logic [7:0] ADDR_RESULT  = 8'h14;
  localparam logic [7:0] ADDR_LEVEL   = 8'h18;

  // Control register fields
  localparam int CTRL_LIM_A_BIT  = 0;
  localparam int CTRL_LIM_B_BIT  = 1;
  localparam int CTRL_STROBE_BIT = 2;

  // Pattern register: four nibbles low_a, high_a, low_b, high_b, then pass
  localparam int PAT_LOW_A  = 0;
  localparam int PAT_HIGH_A = 4;
  localparam int PAT_LOW_B  = 8;
  localparam int PAT_HIGH_B = 12;
  localparam int PAT_PASS   = 16;

  // Result register: write triggers evaluation of one reading
  localparam int RES_LOW_A  = 0;
  localparam int RES_HIGH_A = 1;
  localparam int RES_LOW_B  = 2;
  localparam int RES_HIGH_B = 3;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Reset values
  localparam logic [3:0]  STATE_RST   = 4'h0;
  localparam logic [3:0]  SENSE_RST   = 4'hF;
  localparam logic [19:0] PATTERN_RST = 20'h00000;

  // Strobe width: more than 10 us at 250 MHz
  localparam int STROBE_US      = 10;
  localparam int CLK_MHZ        = 250;
  localparam int STROBE_CYCLES  = STROBE_US * CLK_MHZ + 1;
  localparam int STROBE_LINE    = 3;

  // First member is the top nibble, so pass sits at [19:16] and low_a at [3:0]
  typedef struct packed {
    logic [3:0] pass_pat;
    logic [3:0] high_b;
    logic [3:0] low_b;
    logic [3:0] high_a;
    logic [3:0] low_a;
  } dopc_pattern_t;

endpackage

//--- dopc_top.sv
// Digital output port control: AXI4-Lite slave, line state, limit patterns, strobe
//////////////////////////////////////////////////////////////////////////////
// Contract
// - Four lines, each from its own state or from limit test outcome.
// - A state change request toggles the selected lines' state bits.
// - Per line polarity; active high on drives high, active low on drives low.
// - Low level turns the sink switch on; high level turns it off.
// - Under limit control manual writes ignored; state view detached from outputs.
// - Order low_a, high_a, low_b, high_b; first fail pattern, else pass pattern.
// - With strobe enabled, line four true over 10 us after each evaluation.
// - Enabling strobe forces line four false; disabling leaves it as is. Only the limit-driven line four is forced; manual state still drives it.
module dopc_top #(
  parameter int STROBE_CYCLES = dopc_pkg::STROBE_CYCLES
) (
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  output logic [3:0]       line_level_o,
  output logic [3:0]       line_sink_on_o
);

  localparam int CW = $clog2(STROBE_CYCLES + 1);

  logic [3:0]              manual_state;
  logic [3:0]              sense;
  logic                    lim_a_en;
  logic                    lim_b_en;
  logic                    strobe_en;
  dopc_pkg::dopc_pattern_t pattern;
  logic [3:0]              limit_state;
  logic [CW-1:0]           strobe_cnt;
  logic [7:0]              aw_addr;
  logic [31:0]             w_data;
  logic [3:0]              w_strb;
  logic                    aw_held;
  logic                    w_held;
  logic                    wr_fire;
  logic                    wr_hit;
  logic                    limit_ctrl;
  logic [3:0]              source;
  logic [3:0]              next_pattern;
  logic [31:0]             rd_word;
  logic                    rd_hit;

  assign limit_ctrl = lim_a_en | lim_b_en;
  assign wr_fire    = aw_held & w_held & ~s_axi_bvalid_o;

  // Byte-lane merge for writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Write channel capture: address and data accepted in either order
  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      aw_held         <= 1'b0;
      w_held          <= 1'b0;
      aw_addr         <= 8'h00;
      w_data          <= 32'h0000_0000;
      w_strb          <= 4'h0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o  <= 1'b1;
    end
    else
    begin
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        aw_held         <= 1'b1;
        aw_addr         <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        w_held         <= 1'b1;
        w_data         <= s_axi_wdata_i;
        w_strb         <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      // Reopen only once the response is consumed, so one write at a time
      if (s_axi_bvalid_o && s_axi_bready_i)
      begin
        aw_held         <= 1'b0;
        w_held          <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o  <= 1'b1;
      end
    end
  end

  // Address decode for writes
  always_comb
  begin
    case (aw_addr)
      dopc_pkg::ADDR_STATE, dopc_pkg::ADDR_TOGGLE, dopc_pkg::ADDR_SENSE,
      dopc_pkg::ADDR_CTRL, dopc_pkg::ADDR_PATTERN, dopc_pkg::ADDR_RESULT:
        wr_hit = 1'b1;
      default:
        wr_hit = 1'b0;
    endcase
  end

  // Write response
  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= dopc_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= wr_hit ? dopc_pkg::RESP_OKAY : dopc_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready_i)
    begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Manual state: toggle only, frozen while limits own the lines
  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      manual_state <= dopc_pkg::STATE_RST;
    end
    else if (wr_fire && !limit_ctrl && w_strb[0])
    begin
      if (aw_addr == dopc_pkg::ADDR_TOGGLE)
      begin
        manual_state <= manual_state ^ w_data[3:0];
      end
    end
  end

  // Polarity, control and patterns
  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      sense     <= dopc_pkg::SENSE_RST;
      lim_a_en  <= 1'b0;
      lim_b_en  <= 1'b0;
      strobe_en <= 1'b0;
      pattern   <= dopc_pkg::PATTERN_RST;
    end
    else if (wr_fire)
    begin
      if (aw_addr == dopc_pkg::ADDR_SENSE && w_strb[0])
      begin
        sense <= w_data[3:0];
      end
      if (aw_addr == dopc_pkg::ADDR_CTRL && w_strb[0])
      begin
        lim_a_en  <= w_data[dopc_pkg::CTRL_LIM_A_BIT];
        lim_b_en  <= w_data[dopc_pkg::CTRL_LIM_B_BIT];
        strobe_en <= w_data[dopc_pkg::CTRL_STROBE_BIT];
      end
      if (aw_addr == dopc_pkg::ADDR_PATTERN)
      begin
        pattern <= 20'(merge({12'h000, pattern}, w_data, w_strb));
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Limit evaluation priority: first failing test wins, else pass
  always_comb
  begin
    if (w_data[dopc_pkg::RES_LOW_A])
      next_pattern = pattern.low_a;
    else if (w_data[dopc_pkg::RES_HIGH_A])
      next_pattern = pattern.high_a;
    else if (w_data[dopc_pkg::RES_LOW_B])
      next_pattern = pattern.low_b;
    else if (w_data[dopc_pkg::RES_HIGH_B])
      next_pattern = pattern.high_b;
    else
      next_pattern = pattern.pass_pat;
  end

  // Limit-driven state and binning strobe on line four
  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      limit_state <= 4'h0;
      strobe_cnt  <= '0;
    end
    else
    begin
      if (wr_fire && w_strb[0] && aw_addr == dopc_pkg::ADDR_RESULT && limit_ctrl)
      begin
        limit_state[2:0] <= next_pattern[2:0];
        if (strobe_en)
        begin
          limit_state[dopc_pkg::STROBE_LINE] <= 1'b1;
          strobe_cnt                         <= CW'(STROBE_CYCLES);
        end
        else
        begin
          limit_state[dopc_pkg::STROBE_LINE] <= next_pattern[dopc_pkg::STROBE_LINE];
        end
      end
      else if (wr_fire && aw_addr == dopc_pkg::ADDR_CTRL && w_strb[0]
               && w_data[dopc_pkg::CTRL_STROBE_BIT] && !strobe_en)
      begin
        // Enabling forces line four false here and clears the strobe count
        limit_state[dopc_pkg::STROBE_LINE] <= 1'b0;
        strobe_cnt                         <= '0;
      end
      else if (strobe_cnt != '0 && strobe_en) // paused while disabled, line holds
      begin
        strobe_cnt <= strobe_cnt - CW'(1);
        if (strobe_cnt == CW'(1))
        begin
          limit_state[dopc_pkg::STROBE_LINE] <= 1'b0;
        end
      end
    end
  end

  // Source select then polarity, registered so pins never glitch
  assign source = limit_ctrl ? limit_state : manual_state;
  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      line_level_o   <= ~(dopc_pkg::STATE_RST ^ dopc_pkg::SENSE_RST);
      line_sink_on_o <= dopc_pkg::STATE_RST ^ dopc_pkg::SENSE_RST;
    end
    else
    begin
      line_level_o   <= ~(source ^ sense);
      line_sink_on_o <= source ^ sense;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read path
  always_comb
  begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    case (s_axi_araddr_i)
      dopc_pkg::ADDR_STATE:   rd_word[3:0] = manual_state;
      dopc_pkg::ADDR_TOGGLE:  rd_word = 32'h0000_0000;
      dopc_pkg::ADDR_SENSE:   rd_word[3:0] = sense;
      dopc_pkg::ADDR_CTRL:    rd_word[2:0] = {strobe_en, lim_b_en, lim_a_en};
      dopc_pkg::ADDR_PATTERN: rd_word[19:0] = pattern;
      dopc_pkg::ADDR_RESULT:  rd_word[3:0] = limit_state;
      dopc_pkg::ADDR_LEVEL:   rd_word[3:0] = line_level_o;
      default:                rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= dopc_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b1;
      s_axi_rdata_o   <= rd_word;
      s_axi_rresp_o   <= rd_hit ? dopc_pkg::RESP_OKAY : dopc_pkg::RESP_SLVERR;
    end
    else if (s_axi_rvalid_o && s_axi_rready_i)
    begin
      s_axi_rvalid_o  <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end

endmodule

//--- dopc_load_model.sv
// Far side model: pulled-up open-collector pins with a load on each
module dopc_load_model (
  input  wire logic [3:0] sink_on_i,
  output logic      [3:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pull-up lifts the pin whenever the switch is open
  assign pin_o = ~sink_on_i;
endmodule

//--- dopc_top_asserts.sv
// Checker: bus handshake and line level properties of the port block
module dopc_asserts (
  input wire logic        core_clk_i,
  input wire logic        nrst_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic [3:0]  line_level_o,
  input wire logic [3:0]  line_sink_on_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);
  //////////////////////////////////////////////////////////////////////////////
  // Line drive
  property p_sink_inv; line_sink_on_o == ~line_level_o; endproperty
  a_sink_inv: assert property (p_sink_inv) else $error("sink not inverse of level");
  property p_rst_low; !$past(nrst_i) |-> line_level_o == 4'h0; endproperty
  a_rst_low: assert property (p_rst_low) else $error("lines not low after reset");
  // Bus answers and refusals
  property p_wr_ans; s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
    |-> ##2 s_axi_bvalid_o; endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
  property p_rd_ans; s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  property p_b_end; s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o; endproperty
  a_b_end: assert property (p_b_end) else $error("write response repeated");
  property p_r_end; s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o; endproperty
  a_r_end: assert property (p_r_end) else $error("read response repeated");
  property p_w_busy; s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o; endproperty
  a_w_busy: assert property (p_w_busy) else $error("write accepted while busy");
  property p_r_busy; s_axi_rvalid_o |-> !s_axi_arready_o; endproperty
  a_r_busy: assert property (p_r_busy) else $error("read accepted while busy");
endmodule

bind dopc_top dopc_asserts i_dopc_asserts (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
  .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
  .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
  .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
  .line_level_o(line_level_o), .line_sink_on_o(line_sink_on_o));

//--- digital_output_port_control_test.sv
// Testbench for the digital output port control block
module digital_output_port_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SC = 40; // Short strobe keeps the run brief
  logic        core_clk_i = 1'h0;
  logic        nrst_i = 1'h0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rd, rdata;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [3:0]  lvl, sink, pin;
  logic [3:0]  wstrb = 4'hF;
  logic [3:0]  res [9] = '{4'h0, 4'h1, 4'hF, 4'h2, 4'hE, 4'h4, 4'hC, 4'h8, 4'h0};
  logic [3:0]  pat [9] = '{4'hD, 4'h1, 4'h1, 4'h2, 4'h2, 4'h3, 4'h3, 4'h4, 4'hD};
  int          fail_count = 0, checks = 0, cyc = 0, t0;

  always #2 core_clk_i = ~core_clk_i;

  dopc_top #(.STROBE_CYCLES(SC)) i_dopc_top (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .line_level_o(lvl), .line_sink_on_o(sink));

  dopc_load_model i_dopc_load_model (.sink_on_i(sink), .pin_o(pin));
  //////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fail_count++;
      finish_test();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (e !== g)
    begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask

  task automatic ln(input logic [3:0] e);
    chk("line_level", 32'(e), 32'(lvl));
    chk("pin", 32'(e), 32'(pin));
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = dopc_pkg::RESP_OKAY, input logic [3:0] st = 4'hF);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= st;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do
    begin
      @(posedge core_clk_i);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    bready <= 1'h0;
    chk("bresp", 32'(er), 32'(bresp));
    @(posedge core_clk_i);
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [1:0] er = dopc_pkg::RESP_OKAY);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do
    begin
      @(posedge core_clk_i);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rready <= 1'h0;
    rd = rdata;
    chk("rresp", 32'(er), 32'(rresp));
    @(posedge core_clk_i);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge core_clk_i);
    nrst_i <= 1'h1;
    rd_reg(dopc_pkg::ADDR_SENSE);
    chk("sense", 32'hF, rd);
    ln(4'h0);
    wr(dopc_pkg::ADDR_TOGGLE, 32'h5);
    ln(4'h5);
    wr(dopc_pkg::ADDR_TOGGLE, 32'h4);
    wr(dopc_pkg::ADDR_STATE, 32'hF);
    rd_reg(dopc_pkg::ADDR_STATE);
    chk("state", 32'h1, rd);
    // Mixed sense: on line low, off lines follow their own sense
    wr(dopc_pkg::ADDR_SENSE, 32'h6);
    ln(4'h8);
    wr(8'h1C, 32'h0, dopc_pkg::RESP_SLVERR);
    rd_reg(8'h1C, dopc_pkg::RESP_SLVERR);
    chk("unmapped", 32'h0, rd);
    wr(dopc_pkg::ADDR_LEVEL, 32'h0, dopc_pkg::RESP_SLVERR);
    wr(dopc_pkg::ADDR_SENSE, 32'hF);
    // Lane 0 off: sense untouched; pattern takes only the enabled byte
    wr(dopc_pkg::ADDR_SENSE, 32'h0, dopc_pkg::RESP_OKAY, 4'hE);
    rd_reg(dopc_pkg::ADDR_SENSE);
    chk("sense_lane", 32'hF, rd);
    wr(dopc_pkg::ADDR_PATTERN, 32'hFFFF_FFFF, dopc_pkg::RESP_OKAY, 4'h2);
    rd_reg(dopc_pkg::ADDR_PATTERN);
    chk("pattern_lane", 32'h0000_FF00, rd);
    wr(dopc_pkg::ADDR_PATTERN, 32'hD4321);
    wr(dopc_pkg::ADDR_CTRL, 32'h3);
    wr(dopc_pkg::ADDR_TOGGLE, 32'hF);
    ln(4'h0);
    rd_reg(dopc_pkg::ADDR_STATE);
    chk("state_frozen", 32'h1, rd);
    // Each reading picks the first failing test or the pass pattern
    for (int i = 0; i < 9; i++)
    begin
      wr(dopc_pkg::ADDR_RESULT, 32'(res[i]));
      ln(pat[i]);
    end
    rd_reg(dopc_pkg::ADDR_RESULT);
    chk("limit_state", 32'hD, rd);
    wr(dopc_pkg::ADDR_CTRL, 32'h7);
    ln(4'h5);
    rd_reg(dopc_pkg::ADDR_CTRL);
    chk("ctrl", 32'h7, rd);
    rd_reg(dopc_pkg::ADDR_LEVEL);
    chk("level", 32'h5, rd);
    t0 = cyc;
    wr(dopc_pkg::ADDR_RESULT, 32'h1);
    ln(4'h9);
    while (lvl[3] === 1'h1 && cyc - t0 < 200) @(posedge core_clk_i);
    chk("strobe_len", 32'h1, 32'(cyc - t0 >= SC && cyc - t0 <= SC + 10));
    ln(4'h1);
    wr(dopc_pkg::ADDR_RESULT, 32'h1);
    wr(dopc_pkg::ADDR_CTRL, 32'h3);
    ln(4'h9);
    // Strobe disabled mid pulse: line four must not drop later
    repeat (SC + 10) @(posedge core_clk_i);
    ln(4'h9);
    // Reset in mid-run brings every line back to off
    nrst_i <= 1'h0;
    repeat (2) @(posedge core_clk_i);
    ln(4'h0);
    nrst_i <= 1'h1;
    @(posedge core_clk_i);
    rd_reg(dopc_pkg::ADDR_CTRL);
    chk("ctrl_reset", 32'h0, rd);
    ln(4'h0);
    finish_test();
  end
endmodule
